// ==== hdl/cfg_port_pkg.sv ====
// constants for the serial configuration port
package cfg_port_pkg;
   localparam int WORD_BITS = 32;
   localparam int ADDR_BITS = 5;
   localparam int DATA_BITS = 27;
   localparam int ADDR_LSB = 0;
   localparam int DATA_LSB = 5;
   localparam int NUM_REGS = 32;
   localparam logic [4:0] REG_OUT_LAST = 5'h05;
   localparam logic [4:0] REG_SYS_RESET = 5'h00;
   localparam logic [4:0] REG_MODE = 5'h0b;
   localparam logic [4:0] REG_CAL = 5'h1e;
   localparam int RESET_BIT = 17;
   localparam int EXTRA_CLOCKS = 3;
   localparam logic [1:0] EXTRA_LAST = 2'h3;
   localparam int DIV_LIMIT = 25;
   localparam int DDLY_LIMIT = 12;
   // field positions within data of registers 0..5
   localparam int DIV_LSB = 0;
   localparam int DIV_BITS = 11;
   localparam int DDLY_LSB = 11;
   localparam int DDLY_BITS = 10;
   // mode field and sync/holdover controls in register 11 data
   localparam int MODE_LSB = 22;
   localparam int MODE_BITS = 5;
   localparam int AUTO_SYNC_BIT = 8;
   localparam int HOLD_EN_BIT = 3;
   localparam int DOUBLER_BIT = 4;
   localparam logic [4:0] MODE_DUAL = 5'h00;
   localparam logic [4:0] MODE_DUAL_ZD = 5'h02;
   localparam logic [4:0] MODE_DUAL_EXT = 5'h03;
   localparam logic [4:0] MODE_DUAL_EXT_ZD = 5'h05;
   localparam logic [4:0] MODE_SINGLE = 5'h06;
   localparam logic [4:0] MODE_SINGLE_ZD = 5'h08;
   localparam logic [4:0] MODE_SINGLE_EXT = 5'h0b;
   localparam logic [4:0] MODE_DIST = 5'h10;
   typedef enum logic [1:0] {
      SRC_OSC, SRC_REF0, SRC_REF1, SRC_REF2
   } ref_src_e;
endpackage

// ==== hdl/mode_router.sv ====
// routing of references and feedback for each operating mode
`timescale 1ns/1ps
module mode_router
   import cfg_port_pkg::*;
(
   // configuration
   input wire logic [4:0] mode,
   input wire logic [1:0] ref_select,
   input wire logic ext_feedback,
   input wire logic doubler_en,
   input wire logic holdover_en,
   input wire logic ref_lost,
   // routing results
   output logic jcl_power_down,
   output logic [1:0] jcl_ref_src,
   output logic jcl_fb_from_output,
   output logic syn_ref_from_osc,
   output logic syn_ref_doubled,
   output logic syn_fb_from_output,
   output logic fb_from_pin,
   output logic dist_from_ref1,
   output logic tune_freeze
);
   logic dual;
   logic zd;
   always_comb begin
      dual = 1'b0;
      zd = 1'b0;
      dist_from_ref1 = 1'b0;
      unique case (mode)
         MODE_DUAL, MODE_DUAL_EXT: dual = 1'b1;
         MODE_DUAL_ZD, MODE_DUAL_EXT_ZD: begin
            dual = 1'b1;
            zd = 1'b1;
         end
         MODE_SINGLE, MODE_SINGLE_EXT: ;
         MODE_SINGLE_ZD: zd = 1'b1;
         MODE_DIST: dist_from_ref1 = 1'b1;
         default: ;
      endcase
      jcl_power_down = !dual;
      // reference 0..2 only; osc code falls back to reference 0
      jcl_ref_src = (dual && ref_select != SRC_OSC) ? ref_select
         : SRC_REF0;
      jcl_fb_from_output = dual && zd;
      syn_fb_from_output = !dual && zd && !dist_from_ref1;
      fb_from_pin = zd && ext_feedback;
      syn_ref_from_osc = !dist_from_ref1;
      syn_ref_doubled = syn_ref_from_osc && doubler_en;
      tune_freeze = dual && holdover_en && ref_lost;
   end
endmodule

// ==== hdl/serial_config_port.sv ====
// serial write port: shift, latch, extra clocks, sync and modes
`timescale 1ns/1ps
// What this block does
// - address in bits 0-4, data 5-31
// - sample data on each serial clock rise while latch is low
// - latch pulse copies data into addressed register
// - register 30 write starts frequency calibration
// - large divider/delay need three extra clocks
// - delay staged, applied at next sync
// - auto sync on latch fall after 0-5
// - small or unchanged values need no extras
// - single loop: cleaner off, oscillator is reference
// - dual loop: reference 0-2, oscillator feedback
// - zero-delay dual: output feeds cleaner feedback
// - zero-delay single: output feeds synthesis feedback
// - distribution: reference 1 feeds dividers
// - oscillator buffered, up to four outputs
// - synthesis reference may pass doubler
// - holdover freezes cleaner tuning voltage
// - reset bit in register 0 restores defaults
module serial_config_port
   import cfg_port_pkg::*;
#(
   parameter int GROUPS = 6,
   parameter logic [DATA_BITS-1:0] RESET_VALUE = 27'h0000000
)(
   // clock and reset (serial clock drives this block)
   input wire logic mclk,
   input wire logic reset_n,
   // serial pins
   input wire logic serial_data_pin,
   input wire logic latch_enable_pin,
   // status inputs
   input wire logic ref_lost,
   // per group active divider and delay
   output logic [GROUPS*DIV_BITS-1:0] output_group_divider,
   output logic [GROUPS*DDLY_BITS-1:0] output_group_digital_delay,
   output logic sync_event,
   output logic cal_start,
   // raw register view
   output logic [NUM_REGS*DATA_BITS-1:0] reg_data,
   // routing
   output logic jcl_power_down,
   output logic [1:0] jcl_ref_src,
   output logic jcl_fb_from_output,
   output logic syn_ref_from_osc,
   output logic syn_ref_doubled,
   output logic syn_fb_from_output,
   output logic fb_from_pin,
   output logic dist_from_ref1,
   output logic osc_buffer_en,
   output logic [3:0] osc_to_outputs,
   output logic tune_freeze
);
   typedef struct packed {
      logic [WORD_BITS-1:0] shift;
      logic le_d;
      logic [NUM_REGS*DATA_BITS-1:0] regs;
      logic [GROUPS*DIV_BITS-1:0] div_act;
      logic [GROUPS*DDLY_BITS-1:0] ddly_stage;
      logic [GROUPS*DDLY_BITS-1:0] ddly_act;
      logic [1:0] extra_cnt;
      logic pend;
      logic [2:0] pend_grp;
      logic sync_p;
      logic cal_p;
      logic auto_pend;
   } state_s;
   state_s st_reg;
   state_s st_next;
   logic [ADDR_BITS-1:0] waddr;
   logic [DATA_BITS-1:0] wdata;
   logic le_rise;
   logic le_fall;
   logic auto_sync;
   logic [DATA_BITS-1:0] mode_reg;
   logic [MODE_BITS-1:0] mode_code;
   logic [DIV_BITS-1:0] wdiv;
   assign waddr = st_reg.shift[ADDR_LSB +: ADDR_BITS];
   assign wdata = st_reg.shift[DATA_LSB +: DATA_BITS];
   assign le_rise = latch_enable_pin && !st_reg.le_d;
   assign le_fall = !latch_enable_pin && st_reg.le_d;
   assign mode_reg = st_reg.regs[REG_MODE*DATA_BITS +: DATA_BITS];
   assign auto_sync = mode_reg[AUTO_SYNC_BIT];
   assign mode_code = mode_reg[MODE_LSB +: MODE_BITS];
   assign wdiv = wdata[DIV_LSB +: DIV_BITS];
   always_comb begin
      logic [DIV_BITS-1:0] ndiv;
      logic [DDLY_BITS-1:0] nddly;
      logic big;
      int g;
      ndiv = '0;
      nddly = '0;
      big = 1'b0;
      g = 0;
      st_next = st_reg;
      st_next.le_d = latch_enable_pin;
      st_next.sync_p = 1'b0;
      st_next.cal_p = 1'b0;
      // shifting only while latch is low; msb first arrives at top
      if (!latch_enable_pin) begin
         st_next.shift = {st_reg.shift[WORD_BITS-2:0],
            serial_data_pin};
      end
      // extra clocks count on every edge after a big write
      if (st_reg.pend) begin
         if (st_reg.extra_cnt == EXTRA_LAST - 2'h1) begin
            g = int'(st_reg.pend_grp);
            st_next.div_act[g*DIV_BITS +: DIV_BITS] =
               st_reg.regs[g*DATA_BITS + DIV_LSB +: DIV_BITS];
            st_next.ddly_stage[g*DDLY_BITS +: DDLY_BITS] =
               st_reg.regs[g*DATA_BITS + DDLY_LSB +: DDLY_BITS];
            st_next.pend = 1'b0;
            st_next.extra_cnt = '0;
         end else begin
            st_next.extra_cnt = st_reg.extra_cnt + 2'h1;
         end
      end
      if (le_rise) begin
         if (waddr == REG_SYS_RESET && wdata[RESET_BIT]) begin
            st_next.regs = {NUM_REGS{RESET_VALUE}};
            st_next.pend = 1'b0;
         end else begin
            st_next.regs[waddr*DATA_BITS +: DATA_BITS] = wdata;
         end
         if (waddr == REG_CAL) begin
            st_next.cal_p = 1'b1;
         end
         if (waddr <= REG_OUT_LAST) begin
            ndiv = wdata[DIV_LSB +: DIV_BITS];
            nddly = wdata[DDLY_LSB +: DDLY_BITS];
            g = int'(waddr);
            // threshold shift stages are modelled as a pending load
            big = (ndiv > DIV_BITS'(DIV_LIMIT)
               || nddly > DDLY_BITS'(DDLY_LIMIT))
               && (ndiv != st_reg.div_act[g*DIV_BITS +: DIV_BITS]
               || nddly != st_reg.ddly_stage[g*DDLY_BITS +: DDLY_BITS]);
            if (g < GROUPS) begin
               if (big) begin
                  st_next.pend = 1'b1;
                  st_next.pend_grp = waddr[2:0];
                  st_next.extra_cnt = '0;
               end else begin
                  st_next.div_act[g*DIV_BITS +: DIV_BITS] = ndiv;
                  st_next.ddly_stage[g*DDLY_BITS +: DDLY_BITS] = nddly;
               end
            end
            st_next.auto_pend = auto_sync;
         end else begin
            st_next.auto_pend = 1'b0;
         end
      end
      // auto sync fires as latch falls; host supplied extras first
      if (le_fall && st_reg.auto_pend) begin
         st_next.sync_p = 1'b1;
         st_next.auto_pend = 1'b0;
      end
      if (st_reg.sync_p) begin
         st_next.ddly_act = st_reg.ddly_stage;
      end
   end
   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         st_reg <= '0;
      end else begin
         st_reg <= st_next;
      end
   end
   assign output_group_divider = st_reg.div_act;
   assign output_group_digital_delay = st_reg.ddly_act;
   assign sync_event = st_reg.sync_p;
   assign cal_start = st_reg.cal_p;
   assign reg_data = st_reg.regs;
   // oscillator copy to buffered outputs and four clock outputs
   assign osc_buffer_en = 1'b1;
   assign osc_to_outputs = mode_reg[3:0] & 4'hf;
   mode_router u_router (
      .mode(mode_reg[MODE_LSB +: MODE_BITS]),
      .ref_select(mode_reg[DOUBLER_BIT+2 +: 2]),
      .ext_feedback(mode_reg[DOUBLER_BIT+1]),
      .doubler_en(mode_reg[DOUBLER_BIT]),
      .holdover_en(mode_reg[HOLD_EN_BIT]),
      .ref_lost(ref_lost),
      .jcl_power_down(jcl_power_down),
      .jcl_ref_src(jcl_ref_src),
      .jcl_fb_from_output(jcl_fb_from_output),
      .syn_ref_from_osc(syn_ref_from_osc),
      .syn_ref_doubled(syn_ref_doubled),
      .syn_fb_from_output(syn_fb_from_output),
      .fb_from_pin(fb_from_pin),
      .dist_from_ref1(dist_from_ref1),
      .tune_freeze(tune_freeze)
   );
   // checks
   sequence s_write_cal;
      le_rise && waddr == REG_CAL;
   endsequence
   sequence s_big_write;
      le_rise && waddr <= REG_OUT_LAST && st_next.pend;
   endsequence
   sequence s_small_write;
      le_rise && waddr <= REG_OUT_LAST && !st_next.pend;
   endsequence
   sequence s_quiet_fall;
      le_fall && !st_reg.auto_pend;
   endsequence
   sequence s_other_write;
      le_rise && waddr != REG_CAL;
   endsequence
   chk_cal_pulse: assert property (@(posedge mclk) disable iff (!reset_n)
      s_write_cal |=> cal_start ##1 !cal_start)
      else $error("calibration pulse missing");
   chk_latch_store: assert property (@(posedge mclk)
      disable iff (!reset_n)
      le_rise && !(waddr == REG_SYS_RESET && wdata[RESET_BIT])
      |=> reg_data[$past(waddr)*DATA_BITS +: DATA_BITS]
      == $past(wdata))
      else $error("latched data not stored");
   chk_shift_in: assert property (@(posedge mclk) disable iff (!reset_n)
      !latch_enable_pin |=> st_reg.shift[0] == $past(serial_data_pin))
      else $error("serial bit not shifted");
   chk_hold_shift: assert property (@(posedge mclk)
      disable iff (!reset_n)
      latch_enable_pin |=> $stable(st_reg.shift))
      else $error("shift moved while latch high");
   chk_extra_load: assert property (@(posedge mclk)
      disable iff (!reset_n)
      s_big_write ##1 (st_reg.pend && !le_rise)[*3] |=> !st_reg.pend)
      else $error("big value not loaded after extras");
   chk_auto_sync: assert property (@(posedge mclk) disable iff (!reset_n)
      le_fall && st_reg.auto_pend |=> sync_event)
      else $error("auto sync missing");
   chk_sync_src: assert property (@(posedge mclk) disable iff (!reset_n)
      sync_event |-> $past(le_fall))
      else $error("sync without latch fall");
   chk_delay_stage: assert property (@(posedge mclk)
      disable iff (!reset_n)
      !$past(sync_event) |-> $stable(output_group_digital_delay))
      else $error("delay changed without sync");
   chk_single_mode: assert property (@(posedge mclk)
      disable iff (!reset_n)
      mode_reg[MODE_LSB +: MODE_BITS] == MODE_SINGLE
      |-> jcl_power_down && syn_ref_from_osc)
      else $error("single loop routing wrong");
   chk_reset_bit: assert property (@(posedge mclk) disable iff (!reset_n)
      le_rise && waddr == REG_SYS_RESET && wdata[RESET_BIT]
      |=> reg_data == {NUM_REGS{RESET_VALUE}})
      else $error("reset bit did not restore defaults");
   // a big value must not reach the divider before its extra clocks
   chk_no_early_load: assert property (@(posedge mclk)
      disable iff (!reset_n)
      s_big_write |=> $stable(output_group_divider)
      ##1 $stable(output_group_divider))
      else $error("big divider loaded too early");
   chk_small_direct: assert property (@(posedge mclk)
      disable iff (!reset_n)
      s_small_write |=> output_group_divider[$past(waddr)*DIV_BITS
      +: DIV_BITS] == $past(wdiv))
      else $error("small divider not applied at once");
   chk_regs_idle: assert property (@(posedge mclk)
      disable iff (!reset_n)
      !le_rise |=> $stable(reg_data))
      else $error("register changed without latch");
   chk_cal_only: assert property (@(posedge mclk)
      disable iff (!reset_n)
      s_other_write |=> !cal_start)
      else $error("calibration without its register");
   chk_sync_pulse: assert property (@(posedge mclk)
      disable iff (!reset_n)
      sync_event |=> !sync_event)
      else $error("sync pulse longer than one cycle");
   chk_auto_only: assert property (@(posedge mclk)
      disable iff (!reset_n)
      s_quiet_fall |=> !sync_event)
      else $error("sync without auto setting");
   // routing follows the stored mode; checked on every cycle
   chk_dual_route: assert property (@(posedge mclk)
      disable iff (!reset_n)
      mode_code == MODE_DUAL |-> !jcl_power_down
      && jcl_ref_src != SRC_OSC && syn_ref_from_osc)
      else $error("dual loop routing wrong");
   chk_dual_ext: assert property (@(posedge mclk)
      disable iff (!reset_n)
      mode_code == MODE_DUAL_EXT |-> !jcl_power_down
      && jcl_ref_src != SRC_OSC && !jcl_fb_from_output)
      else $error("dual loop external routing wrong");
   chk_dual_zd: assert property (@(posedge mclk)
      disable iff (!reset_n)
      mode_code == MODE_DUAL_ZD |-> jcl_fb_from_output
      && !syn_fb_from_output)
      else $error("zero-delay dual feedback wrong");
   chk_dual_zd_pin: assert property (@(posedge mclk)
      disable iff (!reset_n)
      mode_code == MODE_DUAL_ZD && mode_reg[DOUBLER_BIT+1]
      |-> fb_from_pin)
      else $error("zero-delay dual pin feedback wrong");
   chk_single_zd: assert property (@(posedge mclk)
      disable iff (!reset_n)
      mode_code == MODE_SINGLE_ZD |-> syn_fb_from_output
      && jcl_power_down && !jcl_fb_from_output)
      else $error("zero-delay single feedback wrong");
   chk_single_zd_pin: assert property (@(posedge mclk)
      disable iff (!reset_n)
      mode_code == MODE_SINGLE_ZD && mode_reg[DOUBLER_BIT+1]
      |-> fb_from_pin)
      else $error("zero-delay single pin feedback wrong");
   chk_single_ext: assert property (@(posedge mclk)
      disable iff (!reset_n)
      mode_code == MODE_SINGLE_EXT |-> jcl_power_down
      && syn_ref_from_osc)
      else $error("single loop external routing wrong");
   chk_dist_route: assert property (@(posedge mclk)
      disable iff (!reset_n)
      mode_code == MODE_DIST |-> dist_from_ref1
      && !syn_ref_from_osc)
      else $error("distribution routing wrong");
   chk_doubler_path: assert property (@(posedge mclk)
      disable iff (!reset_n)
      syn_ref_doubled |-> syn_ref_from_osc)
      else $error("doubler without oscillator reference");
   // freezing a powered-down loop would be meaningless
   chk_freeze_cond: assert property (@(posedge mclk)
      disable iff (!reset_n)
      tune_freeze |-> ref_lost && !jcl_power_down)
      else $error("tuning frozen without lost reference");
endmodule

// ==== verification/cfg_host.sv ====
// host model that shifts words into the serial configuration port
`timescale 1ns/1ps
module cfg_host (
   // serial clock shared with the device
   input wire logic mclk,
   // serial pins
   output logic serial_data_pin,
   output logic latch_enable_pin
);
   initial begin
      serial_data_pin = 1'b0;
      latch_enable_pin = 1'b0;
   end

   // pins change only at falling edges, clear of the device's sampling rise
   task automatic write_word(input logic [4:0] addr,
                             input logic [26:0] data, input int extra);
      logic [31:0] word;
      word = {data, addr};
      for (int i = 31; i >= 0; i--) begin
         @(negedge mclk);
         latch_enable_pin <= 1'b0;
         serial_data_pin <= word[i];
      end
      @(negedge mclk);
      latch_enable_pin <= 1'b1;
      // data line is no longer meaningful: show the inverse, not a held bit
      serial_data_pin <= ~word[0];
      // extra rises with latch high so large values load before any sync
      repeat (extra) @(negedge mclk);
      @(negedge mclk);
      latch_enable_pin <= 1'b0;
   endtask
endmodule

// ==== verification/tb.sv ====
// testbench for the serial configuration port
`timescale 1ns/1ps
module tb;
   import cfg_port_pkg::*;
   logic mclk = 1'b0;
   logic reset_n = 1'b0;
   logic ref_lost = 1'b0;
   logic serial_data_pin;
   logic latch_enable_pin;
   logic [6*DIV_BITS-1:0] div;
   logic [6*DDLY_BITS-1:0] dly;
   logic sync_event;
   logic cal_start;
   logic [NUM_REGS*DATA_BITS-1:0] reg_data;
   logic jcl_power_down;
   logic dist_from_ref1;
   logic tune_freeze;
   int fail_count = 0;
   int n_tests = 0;
   int n_sync = 0;
   int n_cal = 0;
   int s;
   logic [4:0] modes [8] = '{MODE_DUAL, MODE_DUAL_ZD, MODE_DUAL_EXT,
      MODE_DUAL_EXT_ZD, MODE_SINGLE, MODE_SINGLE_ZD, MODE_SINGLE_EXT,
      MODE_DIST};

   always #25 mclk = ~mclk;

   cfg_host cfg_host_inst (
      .mclk(mclk),
      .serial_data_pin(serial_data_pin),
      .latch_enable_pin(latch_enable_pin)
   );

   serial_config_port serial_config_port_inst (
      .mclk(mclk),
      .reset_n(reset_n),
      .serial_data_pin(serial_data_pin),
      .latch_enable_pin(latch_enable_pin),
      .ref_lost(ref_lost),
      .output_group_divider(div),
      .output_group_digital_delay(dly),
      .sync_event(sync_event),
      .cal_start(cal_start),
      .reg_data(reg_data),
      .jcl_power_down(jcl_power_down),
      .jcl_ref_src(),
      .jcl_fb_from_output(),
      .syn_ref_from_osc(),
      .syn_ref_doubled(),
      .syn_fb_from_output(),
      .fb_from_pin(),
      .dist_from_ref1(dist_from_ref1),
      .osc_buffer_en(),
      .osc_to_outputs(),
      .tune_freeze(tune_freeze)
   );

   // pulses last one cycle, so count them as they pass
   always @(posedge mclk) begin
      if (sync_event === 1'b1) n_sync++;
      if (cal_start === 1'b1) n_cal++;
   end

   task stop_test;
      if (fail_count == 0 && n_tests > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask

   task check(input logic [26:0] got, input logic [26:0] exp,
              input string m);
      n_tests++;
      if (got !== exp) begin
         fail_count++;
         $display("ERROR %0t %s got %h exp %h", $time, m, got, exp);
      end
   endtask

   function logic [26:0] rd(input int a);
      return reg_data[a*DATA_BITS +: DATA_BITS];
   endfunction

   task wr(input logic [4:0] a, input logic [26:0] d, input int extra);
      cfg_host_inst.write_word(a, d, extra);
      repeat (4) @(negedge mclk);
   endtask

   initial begin
      repeat (20000) @(posedge mclk);
      fail_count++;
      $display("ERROR %0t run did not finish", $time);
      stop_test();
   end

   initial begin
      repeat (10) @(negedge mclk);
      reset_n = 1'b1;
      @(negedge mclk);
      check(rd(7), 27'h0, "register after reset");
      wr(5'h07, 27'h5a3c0f1, 3);
      check(rd(7), 27'h5a3c0f1, "stored word");
      check(rd(6), 27'h0, "other register untouched");
      for (int i = 0; i < 8; i++) begin
         wr(REG_MODE, {modes[i], 22'h0}, 0);
         check(jcl_power_down, modes[i] >= MODE_SINGLE, "power");
         check(dist_from_ref1, modes[i] == MODE_DIST, "dist");
      end
      wr(REG_MODE, 27'(1 << HOLD_EN_BIT), 0);
      ref_lost = 1'b1;
      @(negedge mclk);
      check(tune_freeze, 1'b1, "holdover freeze");
      ref_lost = 1'b0;
      @(negedge mclk);
      check(tune_freeze, 1'b0, "holdover release");
      // auto sync off: the delay must wait for a later sync
      wr(REG_MODE, 27'h0, 0);
      s = n_sync;
      wr(5'h01, {6'h0, 10'd5, 11'd40}, 3);
      check(div[DIV_BITS +: DIV_BITS], 27'd40, "divider extras");
      check(dly[DDLY_BITS +: DDLY_BITS], 27'h0, "delay staged");
      check(27'(n_sync - s), 27'h0, "no sync without auto");
      wr(5'h03, {6'h0, 10'd2, 11'd20}, 0);
      check(div[3*DIV_BITS +: DIV_BITS], 27'd20, "small divider");
      // auto sync on latch fall applies every staged delay
      wr(REG_MODE, 27'(1 << AUTO_SYNC_BIT), 0);
      s = n_sync;
      wr(5'h02, {6'h0, 10'd13, 11'd30}, 3);
      check(27'(n_sync - s), 27'h1, "auto sync");
      check(div[2*DIV_BITS +: DIV_BITS], 27'd30, "divider auto");
      check(dly[2*DDLY_BITS +: DDLY_BITS], 27'd13, "delay");
      check(dly[DDLY_BITS +: DDLY_BITS], 27'd5, "staged delay");
      // register 29 is written before register 30: calibration only on its register
      s = n_cal;
      wr(5'h1d, 27'h00abc, 0);
      check(27'(n_cal - s), 27'h0, "no calibration");
      wr(REG_CAL, 27'h1234, 0);
      check(27'(n_cal - s), 27'h1, "calibration start");
      wr(REG_SYS_RESET, 27'(1 << RESET_BIT), 0);
      check(rd(7), 27'h0, "defaults after reset bit");
      check(rd(REG_CAL), 27'h0, "defaults after reset bit");
      wr(REG_SYS_RESET, 27'h0, 0);
      stop_test();
   end
endmodule
